// ---- imgsig_pkg.sv ----
// package for the image signature stamp inserter: layout, timing and states
package imgsig_pkg;
  localparam int STAMP_BYTES    = 48;
  localparam int IDX_W          = 6;
  // first stamp byte of each field (zero based: byte 1 is index 0)
  localparam logic [5:0] POS_CYCLE   = 6'h00;
  localparam logic [5:0] POS_FRAME   = 6'h04;
  localparam logic [5:0] POS_TRIG    = 6'h08;
  localparam logic [5:0] POS_LEFT    = 6'h0C;
  localparam logic [5:0] POS_TOP     = 6'h0E;
  localparam logic [5:0] POS_WIDTH   = 6'h10;
  localparam logic [5:0] POS_HEIGHT  = 6'h12;
  localparam logic [5:0] POS_EXPO    = 6'h14;
  localparam logic [5:0] POS_GAIN    = 6'h18;
  localparam logic [5:0] POS_OUTLVL  = 6'h1C;
  localparam logic [5:0] POS_INLVL   = 6'h20;
  localparam logic [5:0] POS_STEP    = 6'h24;
  localparam logic [5:0] POS_FMT     = 6'h26;
  localparam logic [5:0] POS_SERIAL  = 6'h28;
  localparam logic [5:0] POS_USER    = 6'h2C;
  // bus cycle time field layout
  localparam int CYC_OFS_W      = 12;
  localparam int CYC_CNT_W      = 13;
  localparam int CYC_SEC_W      = 7;
  localparam int CYC_CNT_POS    = 12;
  localparam int CYC_SEC_POS    = 25;
  localparam logic [7:0] RSVD_BYTE = 8'h00;
  // per-line state of the inserter
  typedef enum logic [1:0] {IMGSIG_IDLE, IMGSIG_PASS, IMGSIG_STAMP} imgsig_state_type;
endpackage

// ---- imgsig_byte_pick.sv ----
// little-endian byte picker: one byte of a multi-byte field by stamp index
module imgsig_byte_pick
  import imgsig_pkg::*;
#(
  parameter int NBYTES = 4
) (
  // selection
  input  wire logic [IDX_W-1:0]    idx,
  input  wire logic [IDX_W-1:0]    base,
  input  wire logic [8*NBYTES-1:0] field,
  // result
  output logic                     hit,
  output logic [7:0]               byte_out
);
  logic [IDX_W-1:0] rel;
  // low byte sits at the lowest index, so rel selects bits 8*rel upward
  always_comb begin
    rel      = idx - base;
    hit      = (idx >= base) && (rel < IDX_W'(NBYTES));
    byte_out = hit ? field[8*rel +: 8] : 8'h00;
  end
endmodule

// ---- imgsig_inserter.sv ----
// image signature stamp inserter: overwrites the head of one image line
module imgsig_inserter
  import imgsig_pkg::*;
#(
  parameter int SEQ_DEPTH = 16,
  parameter int SEQ_W     = 4
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  // control
  input  wire logic                 stamp_enable,
  input  wire logic [15:0]          stamp_line_position,
  input  wire logic                 sequence_mode,
  input  wire logic [7:0]           sequence_step_index,
  // user word table write port
  input  wire logic                 user_word_we,
  input  wire logic [SEQ_W-1:0]     user_word_addr,
  input  wire logic [31:0]          user_word_data,
  // stamp field sources
  input  wire logic [CYC_OFS_W-1:0] cycle_offset,
  input  wire logic [CYC_CNT_W-1:0] cycle_count,
  input  wire logic [CYC_SEC_W-1:0] second_count,
  input  wire logic [31:0]          frame_tally,
  input  wire logic [31:0]          trigger_tally,
  input  wire logic [15:0]          region_left,
  input  wire logic [15:0]          region_top,
  input  wire logic [15:0]          region_width,
  input  wire logic [15:0]          region_height,
  input  wire logic [31:0]          exposure_time,
  input  wire logic [15:0]          gain_setting,
  input  wire logic [31:0]          output_line_level,
  input  wire logic [15:0]          input_line_level,
  input  wire logic [7:0]           pixel_format_code,
  input  wire logic [31:0]          unit_serial_value,
  // sensor pixel stream
  input  wire logic                 in_valid,
  input  wire logic [7:0]           in_data,
  input  wire logic                 in_frame_start,
  input  wire logic                 in_line_start,
  output logic                      in_ready,
  // outgoing image stream
  output logic                      out_valid,
  output logic [7:0]                out_data,
  output logic                      out_frame_start,
  output logic                      out_line_start,
  input  wire logic                 out_ready
);

  // user word per sequence entry; a handful of words, so a plain array
  logic [31:0] user_mem [SEQ_DEPTH];

  always_ff @(posedge sys_clk) begin
    if (clk_en && user_word_we) begin
      user_mem[user_word_addr] <= user_word_data;
    end
  end

  // snapshot of every field; 48 bytes flat, byte 1 in bits 7:0
  logic [8*STAMP_BYTES-1:0] snap_q, snap_d;
  logic [15:0]              target_q, target_d;
  logic [15:0]              row_q, row_d;
  logic [IDX_W-1:0]         idx_q, idx_d;
  imgsig_state_type         state_q, state_d;
  logic                     en_q, en_d;
  logic                     out_valid_q, out_valid_d;
  logic [7:0]               out_data_q, out_data_d;
  logic                     out_fs_q, out_fs_d;
  logic                     out_ls_q, out_ls_d;
  logic [31:0]              cycle_word;
  logic [31:0]              user_sel;
  logic [15:0]              row_now;
  logic                     take;
  logic [7:0]               stamp_byte;

  // cycle word packs seconds over count over offset
  assign cycle_word = {second_count, cycle_count, cycle_offset};
  // active entry's word in sequence mode, entry zero otherwise
  assign user_sel = sequence_mode ? user_mem[sequence_step_index[SEQ_W-1:0]]
                                  : user_mem[0];
  // one-stage pipe: can accept when output slot free or draining
  assign in_ready = !out_valid_q || out_ready;
  assign take     = clk_en && in_valid && in_ready;
  assign row_now  = in_frame_start ? 16'h0000 : (in_line_start ? row_q + 16'h0001 : row_q);
  // snapshot byte for the pixel at idx_q; reserved bytes were zeroed at capture
  assign stamp_byte = snap_q[8*idx_q +: 8];

  // frame capture, row counting and byte substitution
  always_comb begin
    snap_d      = snap_q;
    target_d    = target_q;
    row_d       = row_q;
    idx_d       = idx_q;
    state_d     = state_q;
    en_d        = en_q;
    out_valid_d = out_valid_q;
    out_data_d  = out_data_q;
    out_fs_d    = out_fs_q;
    out_ls_d    = out_ls_q;
    if (clk_en && out_ready) begin
      out_valid_d = 1'b0;
    end
    if (take) begin
      if (in_frame_start) begin
        // all fields frozen at frame start so the stamp is self-consistent
        snap_d = '0;
        snap_d[8*POS_CYCLE  +: 32] = cycle_word;
        snap_d[8*POS_FRAME  +: 32] = frame_tally;
        snap_d[8*POS_TRIG   +: 32] = trigger_tally;
        snap_d[8*POS_LEFT   +: 16] = region_left;
        snap_d[8*POS_TOP    +: 16] = region_top;
        snap_d[8*POS_WIDTH  +: 16] = region_width;
        snap_d[8*POS_HEIGHT +: 16] = region_height;
        snap_d[8*POS_EXPO   +: 32] = exposure_time;
        snap_d[8*POS_GAIN   +: 16] = gain_setting;
        snap_d[8*POS_OUTLVL +: 32] = output_line_level;
        snap_d[8*POS_INLVL  +: 16] = input_line_level;
        snap_d[8*POS_STEP   +: 8]  = sequence_step_index;
        snap_d[8*POS_FMT    +: 8]  = pixel_format_code;
        snap_d[8*POS_SERIAL +: 32] = unit_serial_value;
        snap_d[8*POS_USER   +: 32] = user_sel;
        en_d = stamp_enable;
        // negative position counts back from the region height
        target_d = stamp_line_position[15] ? region_height + stamp_line_position
                                           : stamp_line_position;
      end
      row_d = row_now;
      if (in_frame_start || in_line_start) begin
        idx_d   = '0;
        state_d = ((in_frame_start ? stamp_enable : en_q) &&
                   row_now == (in_frame_start ? (stamp_line_position[15] ?
                   16'(region_height + stamp_line_position) : stamp_line_position)
                   : target_q)) ? IMGSIG_STAMP : IMGSIG_PASS;
      end
      out_valid_d = 1'b1;
      out_fs_d    = in_frame_start;
      out_ls_d    = in_line_start;
      out_data_d  = in_data;
      // stamp replaces the first 48 pixel bytes of the chosen line only
      case (state_d)
        IMGSIG_STAMP: begin
          out_data_d = snap_d[8*idx_d +: 8];
          if (idx_d == IDX_W'(STAMP_BYTES - 1)) begin
            state_d = IMGSIG_PASS;
          end else begin
            idx_d = idx_d + 1'b1;
          end
        end
        IMGSIG_PASS, IMGSIG_IDLE: out_data_d = in_data;
        default: out_data_d = in_data;
      endcase
    end
  end

  // registers for the path above
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      snap_q      <= '0;
      target_q    <= 16'h0000;
      row_q       <= 16'h0000;
      idx_q       <= '0;
      state_q     <= IMGSIG_IDLE;
      en_q        <= 1'b0;
      out_valid_q <= 1'b0;
      out_data_q  <= 8'h00;
      out_fs_q    <= 1'b0;
      out_ls_q    <= 1'b0;
    end else if (clk_en) begin
      snap_q      <= snap_d;
      target_q    <= target_d;
      row_q       <= row_d;
      idx_q       <= idx_d;
      state_q     <= state_d;
      en_q        <= en_d;
      out_valid_q <= out_valid_d;
      out_data_q  <= out_data_d;
      out_fs_q    <= out_fs_d;
      out_ls_q    <= out_ls_d;
    end
  end

  // outputs straight from flip-flops; only in_ready is combinational
  assign out_valid       = out_valid_q;
  assign out_data        = out_data_q;
  assign out_frame_start = out_fs_q;
  assign out_line_start  = out_ls_q;

  // byte picker used as an independent view of the user word placement
  logic       pick_hit;
  logic [7:0] pick_byte;
  imgsig_byte_pick #(.NBYTES(4)) u_pick_user (
    .idx      (idx_q),
    .base     (POS_USER),
    .field    (snap_q[8*POS_USER +: 32]),
    .hit      (pick_hit),
    .byte_out (pick_byte)
  );

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // stamp switch and line selection, decided at the frame start beat
  chk_passthru_off: assert property (take && !stamp_enable && in_frame_start
    |=> out_valid && out_data == $past(in_data))
    else $error("data altered with stamp off");
  chk_stamp_off: assert property (take && !stamp_enable && in_frame_start
    |=> state_q == IMGSIG_PASS)
    else $error("stamp armed although switched off");
  chk_target_neg: assert property (take && in_frame_start && stamp_line_position == 16'hFFFF
    |=> target_q == $past(region_height) - 16'h0001)
    else $error("last row not selected for minus one");
  chk_first_byte: assert property (take && in_frame_start && stamp_enable
    && stamp_line_position == 16'h0000 |=> out_data == $past(cycle_offset[7:0]))
    else $error("first stamp byte is not the cycle low byte");

  // byte order on the stamp line; start beats excluded since they restart the index
  chk_rsvd_zero: assert property (take && state_q == IMGSIG_STAMP &&
    (idx_q == 6'h1A || idx_q == 6'h1B || idx_q == 6'h22 || idx_q == 6'h23 || idx_q == 6'h25 || idx_q == 6'h27)
    && !in_line_start && !in_frame_start |=> out_data == RSVD_BYTE)
    else $error("reserved stamp byte not zero");
  chk_user_order: assert property (take && state_q == IMGSIG_STAMP && pick_hit
    && !in_line_start && !in_frame_start |=> out_data == $past(pick_byte))
    else $error("user word byte out of order");
  chk_stamp_byte: assert property (take && state_q == IMGSIG_STAMP
    && !in_line_start && !in_frame_start |=> out_data == $past(stamp_byte))
    else $error("stamp byte not taken from the snapshot");
  chk_stamp_len: assert property (take && state_q == IMGSIG_STAMP && idx_q == 6'h2F
    && !in_line_start && !in_frame_start |=> state_q == IMGSIG_PASS)
    else $error("stamp longer than 48 bytes");
  chk_tail_pass: assert property (take && state_q == IMGSIG_PASS
    && !in_line_start && !in_frame_start |=> out_data == $past(in_data))
    else $error("pixel byte altered outside the stamp");

  // field placement in the snapshot frozen at the frame start beat
  chk_snap_stable: assert property (clk_en && !(take && in_frame_start)
    |=> $stable(snap_q))
    else $error("stamp fields changed mid frame");
  chk_cycle_lsb: assert property (take && in_frame_start |=>
    snap_q[7:0] == $past(cycle_offset[7:0]) && snap_q[31:25] == $past(second_count))
    else $error("cycle word packed wrongly");
  chk_frame_lsb: assert property (take && in_frame_start |=>
    snap_q[8*POS_FRAME +: 8] == $past(frame_tally[7:0]))
    else $error("frame tally low byte misplaced");
  chk_trig_lsb: assert property (take && in_frame_start |=>
    snap_q[8*POS_TRIG +: 32] == $past(trigger_tally))
    else $error("trigger tally misplaced");
  chk_region_place: assert property (take && in_frame_start |=>
    snap_q[8*POS_LEFT +: 16] == $past(region_left) && snap_q[8*POS_TOP +: 16] == $past(region_top))
    else $error("region corner misplaced");
  chk_size_place: assert property (take && in_frame_start |=>
    snap_q[8*POS_WIDTH +: 16] == $past(region_width) && snap_q[8*POS_HEIGHT +: 16] == $past(region_height))
    else $error("region size misplaced");
  chk_expo_place: assert property (take && in_frame_start |=>
    snap_q[8*POS_EXPO +: 32] == $past(exposure_time))
    else $error("exposure time misplaced");
  chk_gain_place: assert property (take && in_frame_start |=>
    snap_q[8*POS_GAIN +: 16] == $past(gain_setting))
    else $error("gain setting misplaced");
  chk_outlvl_place: assert property (take && in_frame_start |=>
    snap_q[8*POS_OUTLVL +: 32] == $past(output_line_level))
    else $error("output levels misplaced");
  chk_inlvl_place: assert property (take && in_frame_start |=>
    snap_q[8*POS_INLVL +: 16] == $past(input_line_level))
    else $error("input levels misplaced");
  chk_step_fmt: assert property (take && in_frame_start |=>
    snap_q[8*POS_STEP +: 8] == $past(sequence_step_index) && snap_q[8*POS_FMT +: 8] == $past(pixel_format_code))
    else $error("step index or format code misplaced");
  chk_serial_place: assert property (take && in_frame_start |=>
    snap_q[8*POS_SERIAL +: 32] == $past(unit_serial_value))
    else $error("serial value misplaced");
  chk_user_entry: assert property (take && in_frame_start && sequence_mode |=>
    snap_q[8*POS_USER +: 32] == $past(user_mem[sequence_step_index[SEQ_W-1:0]]))
    else $error("user word not from the active entry");

  // a refused byte must wait unchanged, or the host would see a hole in the line
  chk_out_hold: assert property (out_valid && !out_ready
    |=> out_valid && $stable(out_data))
    else $error("waiting output byte changed");
  chk_freeze: assert property (!clk_en
    |=> $stable(out_valid) && $stable(out_data) && $stable(state_q) && $stable(snap_q))
    else $error("state moved with enable low");

  cov_stamp_line: cover property (take && state_d == IMGSIG_STAMP && in_line_start);
  cov_stamp_done: cover property (take && state_q == IMGSIG_STAMP && idx_q == 6'h2F);
  cov_bottom_row: cover property (take && in_frame_start && stamp_line_position[15]);
  cov_backpress:  cover property (out_valid && !out_ready ##1 out_valid && out_ready);
  cov_seq_user:   cover property (take && in_frame_start && sequence_mode);
endmodule

// ---- imgsig_host_model.sv ----
// host side model: sink for the outgoing image stream, keeps one frame
module imgsig_host_model (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // stream from the inserter
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  input  wire logic       out_frame_start,
  input  wire logic       out_line_start,
  output logic            out_ready,
  // test control and capture
  input  wire logic       stall,
  output int              rx_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] rx_mem [0:1023];
  int         tick;
  initial begin
    out_ready = 1'b1;
    rx_cnt = 0;
    tick = 0;
  end
  // take a beat only when valid, ready and enable meet on one edge
  // slow mode accepts one beat in three, so the sender must hold its output
  always @(posedge sys_clk) begin
    if (rst_n && clk_en && out_valid && out_ready) begin
      if (out_frame_start) rx_cnt = 0;
      rx_mem[rx_cnt] = {out_frame_start, out_line_start, out_data};
      rx_cnt = rx_cnt + 1;
    end
    tick = tick + 1;
    out_ready <= #1 !stall || (tick % 3 == 0);
  end
endmodule

// ---- testbench.sv ----
// self-checking bench for the image signature stamp inserter
module testbench import imgsig_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ROWS = 4;
  localparam int COLS = 56;
  logic                 sys_clk, rst_n, clk_en, stamp_enable, sequence_mode, user_word_we, stall, gate;
  logic                 in_valid, in_frame_start, in_line_start, in_ready;
  logic                 out_valid, out_frame_start, out_line_start, out_ready;
  logic [3:0]           user_word_addr;
  logic [7:0]           sequence_step_index, pixel_format_code, in_data, out_data;
  logic [CYC_OFS_W-1:0] cycle_offset;
  logic [CYC_CNT_W-1:0] cycle_count;
  logic [CYC_SEC_W-1:0] second_count;
  logic [15:0]          stamp_line_position, region_left, region_top, region_width, region_height;
  logic [15:0]          gain_setting, input_line_level;
  logic [31:0]          user_word_data, frame_tally, trigger_tally, exposure_time, output_line_level;
  logic [31:0]          unit_serial_value;
  logic [7:0]           exp_s [0:47];
  int                   failures, cmp_count, rx_cnt;

  imgsig_inserter #(.SEQ_DEPTH(16), .SEQ_W(4)) u_imgsig_inserter (.sys_clk, .rst_n, .clk_en, .stamp_enable,
    .stamp_line_position, .sequence_mode, .sequence_step_index, .user_word_we, .user_word_addr, .user_word_data,
    .cycle_offset, .cycle_count, .second_count, .frame_tally, .trigger_tally, .region_left, .region_top,
    .region_width, .region_height, .exposure_time, .gain_setting, .output_line_level, .input_line_level,
    .pixel_format_code, .unit_serial_value, .in_valid, .in_data, .in_frame_start, .in_line_start, .in_ready,
    .out_valid, .out_data, .out_frame_start, .out_line_start, .out_ready);
  imgsig_host_model u_imgsig_host_model (.sys_clk, .rst_n, .clk_en, .out_valid, .out_data, .out_frame_start,
    .out_line_start, .out_ready, .stall, .rx_cnt);

  // 25 MHz clock; gated mode drops the enable on every other cycle
  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) clk_en <= #1 !gate || !clk_en;

  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // hold the beat until an edge that sees ready and enable together
  task automatic send(input logic [7:0] d, input logic fs, input logic ls);
    logic ok;
    in_valid = 1'b1;
    in_data = d;
    in_frame_start = fs;
    in_line_start = ls;
    do begin
      @(negedge sys_clk);
      ok = (in_ready === 1'b1) && clk_en;
      @(posedge sys_clk);
      #1;
    end while (!ok);
  endtask

  function automatic logic [7:0] pix(int r, int c);
    return 8'(r * 8'h25 + c * 8'h03 + 8'h5A);
  endfunction

  // expected stamp, taken from the field inputs as they stand now
  task automatic snap(input logic [31:0] uw);
    logic [383:0] s;
    s = {uw, unit_serial_value, 8'h00, pixel_format_code, 8'h00, sequence_step_index, 16'h0000, input_line_level,
         output_line_level, 16'h0000, gain_setting, exposure_time, region_height, region_width, region_top,
         region_left, trigger_tally, frame_tally, second_count, cycle_count, cycle_offset};
    for (int i = 0; i < STAMP_BYTES; i++) exp_s[i] = s[8*i +: 8];
  endtask

  // one frame through, then every received beat against the stamp or the pixel
  task automatic run_frame(input int srow);
    logic [9:0] want;
    for (int r = 0; r < ROWS; r++)
      for (int c = 0; c < COLS; c++) send(pix(r, c), r == 0 && c == 0, r > 0 && c == 0);
    in_valid = 1'b0;
    for (int n = 0; n < 1000 && rx_cnt < ROWS * COLS; n++) @(posedge sys_clk);
    #1;
    for (int r = 0; r < ROWS; r++)
      for (int c = 0; c < COLS; c++) begin
        want = {r == 0 && c == 0, r > 0 && c == 0, (r == srow && c < STAMP_BYTES) ? exp_s[c] : pix(r, c)};
        check(u_imgsig_host_model.rx_mem[r*COLS+c], want);
      end
  endtask

  task automatic stop_test;
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    failures = 0;
    cmp_count = 0;
    {rst_n, gate, stall, in_valid, in_data, in_frame_start, in_line_start} = '0;
    {user_word_we, user_word_addr, user_word_data, sequence_mode} = '0;
    clk_en = 1'b1;
    stamp_enable = 1'b1;
    stamp_line_position = 16'h0000;
    sequence_step_index = 8'h02;
    {cycle_offset, cycle_count, second_count} = {12'hBCD, 13'h1A5F, 7'h5B};
    {frame_tally, trigger_tally, exposure_time} = {32'h1122_3344, 32'h5566_7788, 32'h99AB_CDEF};
    {region_left, region_top, region_width, region_height} = {16'h0102, 16'h0304, 16'h0506, 16'h0004};
    {gain_setting, input_line_level, pixel_format_code} = {16'hA1B2, 16'hC3D4, 8'hE5};
    {output_line_level, unit_serial_value} = {32'h0F1E_2D3C, 32'h4B5A_6978};
    repeat (4) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    // user word table: entry i holds C0DE000i
    for (int i = 0; i < 4; i++) begin
      user_word_we = 1'b1;
      user_word_addr = 4'(i);
      user_word_data = 32'hC0DE_0000 + 32'(i);
      @(posedge sys_clk);
      #1;
    end
    user_word_we = 1'b0;
    // stamp in the first row, prompt sink
    snap(32'hC0DE_0000);
    run_frame(0);
    // last row counted from the bottom, slow sink, gated enable, sequence entry two
    stamp_line_position = 16'hFFFF;
    sequence_mode = 1'b1;
    stall = 1'b1;
    gate = 1'b1;
    snap(32'hC0DE_0002);
    run_frame(3);
    // switch off: image passes untouched
    stamp_enable = 1'b0;
    stall = 1'b0;
    gate = 1'b0;
    run_frame(-1);
    // fields change after the frame start beat; stamp keeps the old values
    stamp_enable = 1'b1;
    stamp_line_position = 16'h0001;
    sequence_mode = 1'b0;
    snap(32'hC0DE_0000);
    fork
      run_frame(1);
      begin
        repeat (3) @(posedge sys_clk);
        #1;
        {frame_tally, region_left, unit_serial_value} = {32'hDEAD_BEEF, 16'h7777, 32'h0BAD_F00D};
      end
    join
    stop_test();
  end

  // hang guard, far beyond the four frames
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    stop_test();
  end
endmodule
